// >>> common/tws_pkg.sv
/*
  Shared constants of the two-wire event sequencer: flag and event bit
  positions, reset values, buffer sizes and the release data value.
  Assumes the sequencer and its receive buffer are compiled after it.
*/
package tws_pkg;

  // ==========================================================
  // Flag and event positions
  // ==========================================================
  localparam int NUM_FLAGS = 8;
  localparam int FLAG_ADDR_MATCH = 0;
  localparam int FLAG_BYTE_DONE = 1;
  localparam int FLAG_ACK_FAIL = 2;
  localparam int FLAG_STOP_SEEN = 3;
  localparam int FLAG_START_SENT = 4;
  localparam int FLAG_ADDR_SENT = 5;
  localparam int FLAG_ARB_LOST = 6;
  localparam int FLAG_BUS_ERROR = 7;

  // ==========================================================
  // Widths, depths and values
  // ==========================================================
  localparam int BYTE_WIDTH = 8;
  localparam int RX_FIFO_DEPTH = 32;
  localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 8'h00;
  localparam logic [BYTE_WIDTH-1:0] BYTE_RESET = 8'h00;
  localparam logic [BYTE_WIDTH-1:0] RELEASE_BYTE = 8'hff;

  typedef logic [NUM_FLAGS-1:0] tws_flags_t;

endpackage

// >>> verilog/tws_fifo.sv
/*
  Synchronous first-in first-out buffer with valid and ready on both
  sides; width and depth shape the storage and the pointers.
  Assumes one clock and a reset that is already synchronised.
*/
module tws_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic rstN,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W:0] wrPtr;
  logic [PTR_W:0] rdPtr;
  logic doPush;
  logic doPop;

  // ==========================================================
  // Status
  // ==========================================================
  // The extra pointer bit tells a full buffer from an empty one.
  assign outValid = (wrPtr != rdPtr);
  assign inReady = !((wrPtr[PTR_W] != rdPtr[PTR_W]) &&
                     (wrPtr[PTR_W-1:0] == rdPtr[PTR_W-1:0]));
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;
  assign outData = mem[rdPtr[PTR_W-1:0]];

  // ==========================================================
  // Storage and pointers
  // ==========================================================
  always_ff @(posedge clock)
  begin
    if (doPush)
    begin
      mem[wrPtr[PTR_W-1:0]] <= inData;
    end
  end

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
    end
    else
    begin
      if (doPush)
      begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doPop)
      begin
        rdPtr <= rdPtr + 1'b1;
      end
    end
  end

endmodule

// >>> verilog/tws_event_sequencer.sv
/*
  Event flags, two-step flag clearing, interrupt request and low-power
  behaviour of a multimaster two-wire serial interface, with the
  received-byte buffer and the crossings to the bit engine's clock.
  Assumes a bit engine on linkClock that pulses one event bit per event
  and offers received bytes with valid and ready; CPU strobes are
  one-cycle pulses on clock.
*/
// Overview of operation
// - Address match sets pending and match flags; status one read clears.
// - Rx byte sets pending and byte-done; status one, data read clear.
// - Tx byte sets pending and byte-done; status one, data write clear.
// - Nack sets pending, ack-fail, byte-done; status one clears ack-fail.
// - After that, byte-done clears by stop pulse high-low or writing FFh.
// - After a stop-pulse release, the next stop detection is hidden.
// - Slave stop sets pending and stop-seen; status two read clears them.
// - Start sent sets pending, start flag; status one, data write clear.
// - Address sent sets pending and address-sent flag; status one, control write clear.
// - Address-sent and status two errors also set the pending flag.
// - All eight sources may wake from Wait, none from Halt.
// - All events share one interrupt request line.
// - Interrupt request only while the common enable bit is set.
// - Wait leaves the block running; its interrupt ends Wait.
// - Halt freezes flags and refuses to acknowledge bus data.
// - Clock held low on start, byte-done, match or address-sent pending.
// - Block disabled clears all flags and releases clock hold and acknowledge; buffered received bytes and rxValid stay.
module tws_event_sequencer (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic block_enable_bit,
  input wire logic irq_enable_bit,
  input wire logic stopRequest,
  input wire logic cpuWait,
  input wire logic cpuHalt,
  input wire logic statusOneRead,
  input wire logic statusTwoRead,
  input wire logic dataRead,
  input wire logic dataWrite,
  input wire logic controlWrite,
  input wire logic [tws_pkg::BYTE_WIDTH-1:0] cpuWriteData,
  output logic [tws_pkg::NUM_FLAGS-1:0] flagBits,
  output logic event_pending_flag,
  output logic irq,
  output logic waitExit,
  output logic rxValid,
  output logic [tws_pkg::BYTE_WIDTH-1:0] rxByte,
  output logic [tws_pkg::BYTE_WIDTH-1:0] txByte,
  output logic txLoad,
  input wire logic linkClock,
  input wire logic [tws_pkg::NUM_FLAGS-1:0] linkEvent,
  input wire logic linkRxValid,
  output logic linkRxReady,
  input wire logic [tws_pkg::BYTE_WIDTH-1:0] linkRxData,
  output logic linkSclHold,
  output logic linkAckEnable
);
  import tws_pkg::*;

  logic [1:0] rstSync;
  logic sysRstN;
  logic [1:0] linkRstSync;
  logic linkRstN;
  logic [NUM_FLAGS-1:0] evToggle;
  logic [NUM_FLAGS-1:0] evS1;
  logic [NUM_FLAGS-1:0] evS2;
  logic [NUM_FLAGS-1:0] evS3;
  logic [NUM_FLAGS-1:0] hit;
  logic rxReq;
  logic [BYTE_WIDTH-1:0] rxHold;
  logic rqS1;
  logic rqS2;
  logic rqS3;
  logic ackToggle;
  logic akS1;
  logic akS2;
  logic akS3;
  logic rxPending;
  logic rxPush;
  logic rxAck;
  logic fifoInReady;
  tws_flags_t flags;
  tws_flags_t setVec;
  tws_flags_t clrVec;
  tws_flags_t next_flags;
  logic active;
  logic armed;
  logic txDir;
  logic afHold;
  logic stopSuppress;
  logic stopPrev;
  logic stopFall;
  logic sclHoldSys;
  logic ackEnableSys;
  logic [2:0] sclSync;
  logic [2:0] ackSync;

  // ==========================================================
  // Reset release
  // ==========================================================
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rstSync <= 2'h0;
    end
    else
    begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign sysRstN = rstSync[1];

  always_ff @(posedge linkClock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      linkRstSync <= 2'h0;
    end
    else
    begin
      linkRstSync <= {linkRstSync[0], 1'b1};
    end
  end
  assign linkRstN = linkRstSync[1];

  // ==========================================================
  // Event crossing, one toggle per event source
  // ==========================================================
  // A toggle survives any ratio of the two clocks; the bit engine must
  // not repeat the same event faster than about three system clocks.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi++)
    begin : g_event
      always_ff @(posedge linkClock or negedge linkRstN)
      begin
        if (!linkRstN)
        begin
          evToggle[gi] <= 1'b0;
        end
        else
        begin
          evToggle[gi] <= evToggle[gi] ^ linkEvent[gi];
        end
      end

      always_ff @(posedge clock or negedge sysRstN)
      begin
        if (!sysRstN)
        begin
          evS1[gi] <= 1'b0;
          evS2[gi] <= 1'b0;
          evS3[gi] <= 1'b0;
        end
        else
        begin
          evS1[gi] <= evToggle[gi];
          evS2[gi] <= evS1[gi];
          evS3[gi] <= evS2[gi];
        end
      end
      assign hit[gi] = evS2[gi] ^ evS3[gi];
    end
  endgenerate

  // ==========================================================
  // Received byte handshake
  // ==========================================================
  // The byte is held in rxHold from the request toggle until the
  // acknowledge returns, so the system side samples a stable word.
  assign linkRxReady = (rxReq == akS3) && (akS2 == akS3);

  always_ff @(posedge linkClock or negedge linkRstN)
  begin
    if (!linkRstN)
    begin
      rxReq <= 1'b0;
      rxHold <= BYTE_RESET;
    end
    else if (linkRxValid && linkRxReady)
    begin
      rxReq <= !rxReq;
      rxHold <= linkRxData;
    end
  end

  always_ff @(posedge linkClock or negedge linkRstN)
  begin
    if (!linkRstN)
    begin
      akS1 <= 1'b0;
      akS2 <= 1'b0;
      akS3 <= 1'b0;
    end
    else
    begin
      akS1 <= ackToggle;
      akS2 <= akS1;
      akS3 <= akS2;
    end
  end

  always_ff @(posedge clock or negedge sysRstN)
  begin
    if (!sysRstN)
    begin
      rqS1 <= 1'b0;
      rqS2 <= 1'b0;
      rqS3 <= 1'b0;
    end
    else
    begin
      rqS1 <= rxReq;
      rqS2 <= rqS1;
      rqS3 <= rqS2;
    end
  end

  assign active = block_enable_bit && !cpuHalt;
  assign rxPending = (rqS3 != ackToggle) && (rqS2 == rqS3);
  assign rxPush = rxPending && active && fifoInReady;
  // While disabled, bytes are acknowledged and dropped.
  assign rxAck = rxPush || (rxPending && !block_enable_bit);

  always_ff @(posedge clock or negedge sysRstN)
  begin
    if (!sysRstN)
    begin
      ackToggle <= 1'b0;
    end
    else if (rxAck)
    begin
      ackToggle <= !ackToggle;
    end
  end

  tws_fifo #(
    .WIDTH(BYTE_WIDTH),
    .DEPTH(RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .clock(clock),
    .rstN(sysRstN),
    .inValid(rxPending && active),
    .inReady(fifoInReady),
    .inData(rxHold),
    .outValid(rxValid),
    .outReady(dataRead),
    .outData(rxByte)
  );

  // ==========================================================
  // Flag set and clear terms
  // ==========================================================
  assign stopFall = stopPrev && !stopRequest;

  always_comb
  begin
    setVec = hit;
    setVec[FLAG_BYTE_DONE] = rxPush || hit[FLAG_BYTE_DONE] ||
                             hit[FLAG_ACK_FAIL];
    setVec[FLAG_STOP_SEEN] = hit[FLAG_STOP_SEEN] && !stopSuppress;
    clrVec = '0;
    clrVec[FLAG_ADDR_MATCH] = statusOneRead;
    clrVec[FLAG_ACK_FAIL] = statusOneRead;
    clrVec[FLAG_STOP_SEEN] = statusTwoRead;
    clrVec[FLAG_ARB_LOST] = statusTwoRead;
    clrVec[FLAG_BUS_ERROR] = statusTwoRead;
    clrVec[FLAG_BYTE_DONE] = armed && ((dataRead && !txDir) ||
                                       (dataWrite && txDir));
    if (afHold && (stopFall || (dataWrite && cpuWriteData == RELEASE_BYTE)))
    begin
      clrVec[FLAG_BYTE_DONE] = 1'b1;
    end
    clrVec[FLAG_START_SENT] = armed && dataWrite;
    clrVec[FLAG_ADDR_SENT] = armed && controlWrite;
  end

  // ==========================================================
  // Flags
  // ==========================================================
  always_comb
  begin
    if (!block_enable_bit)
    begin
      next_flags = FLAGS_RESET;
    end
    else if (cpuHalt)
    begin
      next_flags = flags;
    end
    // a new event wins over a clear.
    else
    begin
      next_flags = setVec | (flags & ~clrVec);
    end
  end

  always_ff @(posedge clock or negedge sysRstN)
  begin
    if (!sysRstN)
    begin
      flags <= FLAGS_RESET;
      event_pending_flag <= 1'b0;
    end
    else
    begin
      flags <= next_flags;
      event_pending_flag <= |next_flags;
    end
  end
  assign flagBits = flags;

  // ==========================================================
  // Two-step bookkeeping
  // ==========================================================
  // remember the status one read.
  always_ff @(posedge clock or negedge sysRstN)
  begin
    if (!sysRstN)
    begin
      armed <= 1'b0;
    end
    else if (!block_enable_bit)
    begin
      armed <= 1'b0;
    end
    else if (statusOneRead && (|flags))
    begin
      armed <= 1'b1;
    end
    else if (dataRead || dataWrite || controlWrite)
    begin
      armed <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge sysRstN)
  begin
    if (!sysRstN)
    begin
      txDir <= 1'b0;
      afHold <= 1'b0;
    end
    else if (!block_enable_bit)
    begin
      txDir <= 1'b0;
      afHold <= 1'b0;
    end
    else if (!cpuHalt)
    begin
      if (hit[FLAG_BYTE_DONE] || hit[FLAG_ACK_FAIL])
      begin
        txDir <= 1'b1;
      end
      else if (rxPush)
      begin
        txDir <= 1'b0;
      end
      if (hit[FLAG_ACK_FAIL])
      begin
        afHold <= 1'b1;
      end
      else if (!next_flags[FLAG_BYTE_DONE])
      begin
        afHold <= 1'b0;
      end
    end
  end

  // The stop request bit is not cleared by disabling, so neither is
  // its edge history.
  always_ff @(posedge clock or negedge sysRstN)
  begin
    if (!sysRstN)
    begin
      stopPrev <= 1'b0;
    end
    else
    begin
      stopPrev <= stopRequest;
    end
  end

  always_ff @(posedge clock or negedge sysRstN)
  begin
    if (!sysRstN)
    begin
      stopSuppress <= 1'b0;
    end
    else if (!block_enable_bit)
    begin
      stopSuppress <= 1'b0;
    end
    else if (afHold && stopFall && !cpuHalt)
    begin
      stopSuppress <= 1'b1;
    end
    else if (hit[FLAG_STOP_SEEN] && !cpuHalt)
    begin
      stopSuppress <= 1'b0;
    end
  end

  // ==========================================================
  // Interrupt, wake and data register
  // ==========================================================
  // one gated request line.
  assign irq = irq_enable_bit && block_enable_bit && event_pending_flag;
  // interrupt ends Wait; there is no Halt wake output.
  assign waitExit = irq && cpuWait;

  always_ff @(posedge clock or negedge sysRstN)
  begin
    if (!sysRstN)
    begin
      txByte <= BYTE_RESET;
      txLoad <= 1'b0;
    end
    else
    begin
      txLoad <= dataWrite && active;
      if (dataWrite && active)
      begin
        txByte <= cpuWriteData;
      end
    end
  end

  // ==========================================================
  // Levels toward the link
  // ==========================================================
  // clock stretch causes.
  assign sclHoldSys = block_enable_bit && (flags[FLAG_START_SENT] ||
                      flags[FLAG_BYTE_DONE] || flags[FLAG_ADDR_MATCH] ||
                      flags[FLAG_ADDR_SENT]);
  // no acknowledge in Halt or when disabled.
  assign ackEnableSys = active;

  always_ff @(posedge linkClock or negedge linkRstN)
  begin
    if (!linkRstN)
    begin
      sclSync <= 3'h0;
      ackSync <= 3'h0;
    end
    else
    begin
      sclSync <= {sclSync[1:0], sclHoldSys};
      ackSync <= {ackSync[1:0], ackEnableSys};
    end
  end
  assign linkSclHold = sclSync[2];
  assign linkAckEnable = ackSync[2];

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clock); endclocking
  default disable iff (!sysRstN);

  chk_match_clear_read: assert property (
    flags[FLAG_ADDR_MATCH] && statusOneRead && active &&
    !hit[FLAG_ADDR_MATCH] |=> !flags[FLAG_ADDR_MATCH])
    else $error("address match flag not cleared by status one read");

  chk_rx_byte_set: assert property (
    rxPush |=> flags[FLAG_BYTE_DONE] && event_pending_flag)
    else $error("received byte did not set byte-done and pending");

  chk_tx_two_step: assert property (
    armed && txDir && dataWrite && active && !setVec[FLAG_BYTE_DONE]
    |=> !flags[FLAG_BYTE_DONE])
    else $error("byte-done not cleared by data write after read");

  chk_ack_fail_set: assert property (
    hit[FLAG_ACK_FAIL] && active |=> flags[FLAG_ACK_FAIL] &&
    flags[FLAG_BYTE_DONE] && event_pending_flag)
    else $error("ack failure did not set its three flags");

  chk_stop_release: assert property (
    afHold && stopFall && active && !setVec[FLAG_BYTE_DONE]
    |=> !flags[FLAG_BYTE_DONE])
    else $error("stop pulse did not release byte-done");

  chk_stop_hidden: assert property (
    stopSuppress && hit[FLAG_STOP_SEEN] && !flags[FLAG_STOP_SEEN]
    |=> !flags[FLAG_STOP_SEEN])
    else $error("stop reported after stop-pulse release");

  chk_stop_seen_clear: assert property (
    flags[FLAG_STOP_SEEN] && statusTwoRead && active &&
    !setVec[FLAG_STOP_SEEN] |=> !flags[FLAG_STOP_SEEN])
    else $error("stop-seen not cleared by status two read");

  chk_start_needs_read: assert property (
    flags[FLAG_START_SENT] && dataWrite && !armed && active
    |=> flags[FLAG_START_SENT])
    else $error("start flag cleared without prior status read");

  chk_addr_sent_clear: assert property (
    armed && controlWrite && active && !hit[FLAG_ADDR_SENT]
    |=> !flags[FLAG_ADDR_SENT])
    else $error("address-sent event not cleared by control write");

  chk_irq_enable_gate: assert property (
    irq == (irq_enable_bit && block_enable_bit && (|flags)))
    else $error("interrupt request not following enable bit");

  chk_halt_freeze: assert property (
    cpuHalt && block_enable_bit |=> flags == $past(flags))
    else $error("flags changed during Halt");

  chk_pending_all: assert property (
    event_pending_flag |-> (|flags))
    else $error("pending flag set with no contributing flag");

  chk_disable_clear: assert property (
    !block_enable_bit |=> flags == FLAGS_RESET && !armed && !irq)
    else $error("disabled block kept flags or request");

  cov_two_step_rx: cover property (
    armed && dataRead && !txDir && flags[FLAG_BYTE_DONE]);
  cov_ack_fail_release: cover property (afHold && stopFall);
  cov_fifo_full: cover property (rxPending && !fifoInReady);
  cov_wait_wake: cover property (waitExit);

endmodule

// >>> verif/tws_link_model.sv
/*
  Link-side model of the bit engine: event pulses and received bytes.
  Assumes the sequencer samples these on the rising edge of linkClock.
*/
module tws_link_model (
  input wire logic linkClock,
  input wire logic linkRxReady,
  output tws_pkg::tws_flags_t linkEvent,
  output logic linkRxValid,
  output logic [tws_pkg::BYTE_WIDTH-1:0] linkRxData
);
  timeunit 1ns;
  timeprecision 1ps;
  import tws_pkg::*;

  // ==========================================================
  // Line state
  // ==========================================================
  logic readySeen = 1'b0;

  initial
  begin
    linkEvent = '0;
    linkRxValid = 1'b0;
    linkRxData = 8'h5a;
  end

  // Sampled mid-cycle, so the taking edge sees a settled value.
  always @(negedge linkClock) readySeen <= linkRxReady;

  // ==========================================================
  // Transfers
  // ==========================================================
  task automatic pulse(input tws_flags_t bits);
    @(posedge linkClock) linkEvent <= bits;
    @(posedge linkClock) linkEvent <= '0;
  endtask

  // Released data is inverted so a stale byte can never pass.
  task automatic send(input logic [7:0] d, input int limit, output bit taken);
    taken = 1'b0;
    @(posedge linkClock);
    linkRxValid <= 1'b1;
    linkRxData <= d;
    repeat (limit)
    begin
      @(posedge linkClock);
      if (readySeen)
      begin
        taken = 1'b1;
        break;
      end
    end
    linkRxValid <= 1'b0;
    linkRxData <= ~d;
  endtask
endmodule

// >>> verif/tws_event_sequencer_bench.sv
/*
  Self-checking bench of the event sequencer: CPU strobes and link traffic.
  Assumes the link model drives the link side on its own clock.
*/
`define CHK(g, e) \
  begin \
    checksDone++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("Error at %0t ns: got %h expected %h", $time, g, e); \
    end \
  end
module tws_event_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import tws_pkg::*;

  // ==========================================================
  // Signals
  // ==========================================================
  localparam logic [4:0] RD_ONE = 5'h10;
  localparam logic [4:0] RD_TWO = 5'h08;
  localparam logic [4:0] RD_DATA = 5'h04;
  localparam logic [4:0] WR_DATA = 5'h02;
  localparam logic [4:0] WR_CTRL = 5'h01;
  logic clock = 1'b0;
  logic linkClock = 1'b0;
  logic reset_n = 1'b0;
  logic block_enable_bit = 1'b0;
  logic irq_enable_bit = 1'b0;
  logic stopRequest = 1'b0;
  logic cpuWait = 1'b0;
  logic cpuHalt = 1'b0;
  logic statusOneRead = 1'b0;
  logic statusTwoRead = 1'b0;
  logic dataRead = 1'b0;
  logic dataWrite = 1'b0;
  logic controlWrite = 1'b0;
  logic [7:0] cpuWriteData = 8'h00;
  tws_flags_t flagBits, linkEvent;
  logic event_pending_flag, irq, waitExit, rxValid, txLoad;
  logic linkRxValid, linkRxReady, linkSclHold, linkAckEnable;
  logic [7:0] rxByte, txByte, linkRxData;
  int miscompares = 0;
  int checksDone = 0;
  bit taken;
  logic [7:0] loadCount = 8'h00;

  always #12.5 clock = ~clock;
  always #3 linkClock = ~linkClock;
  always @(negedge clock) loadCount <= loadCount + 8'(txLoad);

  tws_event_sequencer i_tws_event_sequencer (.clock, .reset_n,
    .block_enable_bit, .irq_enable_bit, .stopRequest, .cpuWait, .cpuHalt,
    .statusOneRead, .statusTwoRead, .dataRead, .dataWrite, .controlWrite,
    .cpuWriteData, .flagBits, .event_pending_flag, .irq, .waitExit,
    .rxValid, .rxByte, .txByte, .txLoad, .linkClock, .linkEvent,
    .linkRxValid, .linkRxReady, .linkRxData, .linkSclHold, .linkAckEnable);

  tws_link_model i_tws_link_model (.linkClock, .linkRxReady, .linkEvent,
    .linkRxValid, .linkRxData);

  // ==========================================================
  // Tasks
  // ==========================================================
  function automatic tws_flags_t fb(input int i);
    return tws_flags_t'(1) << i;
  endfunction

  // Checks land 1 ns after an edge, once its updates have settled.
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic cpu(input logic [4:0] s, input logic [7:0] d);
    @(posedge clock);
    {statusOneRead, statusTwoRead, dataRead, dataWrite, controlWrite} <= s;
    cpuWriteData <= d;
    @(posedge clock);
    {statusOneRead, statusTwoRead, dataRead, dataWrite, controlWrite} <= '0;
    tick(1);
  endtask

  task automatic ev(input tws_flags_t b);
    i_tws_link_model.pulse(b);
    tick(10);
  endtask

  task automatic closeOut();
    $display("checks %0d, mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // Tests
  // ==========================================================
  initial
  begin
    #150us;
    miscompares++;
    closeOut();
  end

  initial
  begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    tick(4);
    `CHK({event_pending_flag, flagBits}, 9'h000);
    @(posedge clock) block_enable_bit <= 1'b1;
    tick(8);
    `CHK(linkAckEnable, 1'b1);
    ev(fb(FLAG_ADDR_MATCH));
    `CHK({event_pending_flag, flagBits}, {1'b1, fb(FLAG_ADDR_MATCH)});
    `CHK(irq, 1'b0);
    @(posedge clock) irq_enable_bit <= 1'b1;
    tick(2);
    `CHK(irq, 1'b1);
    cpu(RD_ONE, 8'h00);
    tick(1);
    `CHK({event_pending_flag, flagBits, irq}, 10'h000);
    $display("address match test done");
    @(posedge clock) cpuWait <= 1'b1;
    for (int i = 0; i < NUM_FLAGS; i++)
    begin
      if (i == FLAG_ADDR_SENT)
        continue;
      ev(fb(i));
      `CHK({irq, waitExit}, 2'b11);
    end
    @(posedge clock) block_enable_bit <= 1'b0;
    tick(2);
    `CHK({event_pending_flag, flagBits, irq}, 10'h000);
    tick(10);
    `CHK(linkSclHold, 1'b0);
    @(posedge clock) block_enable_bit <= 1'b1;
    tick(8);
    $display("wake and disable test done");
    ev(fb(FLAG_START_SENT));
    `CHK({event_pending_flag, flagBits}, {1'b1, fb(FLAG_START_SENT)});
    `CHK(linkSclHold, 1'b1);
    cpu(WR_DATA, 8'h3c);
    tick(1);
    `CHK(flagBits, fb(FLAG_START_SENT));
    cpu(RD_ONE, 8'h00);
    cpu(WR_DATA, 8'ha6);
    tick(1);
    `CHK({event_pending_flag, flagBits, txByte}, 17'h000a6);
    tick(10);
    `CHK(linkSclHold, 1'b0);
    $display("start test done");
    ev(fb(FLAG_ADDR_SENT) | fb(FLAG_ADDR_MATCH));
    `CHK(event_pending_flag, 1'b1);
    cpu(RD_ONE, 8'h00);
    tick(1);
    `CHK({event_pending_flag, flagBits}, {1'b1, fb(FLAG_ADDR_SENT)});
    cpu(RD_ONE, 8'h00);
    cpu(WR_CTRL, 8'h00);
    tick(1);
    `CHK({event_pending_flag, flagBits}, 9'h000);
    ev(fb(FLAG_BYTE_DONE));
    cpu(RD_ONE, 8'h00);
    cpu(WR_DATA, 8'h11);
    tick(1);
    `CHK({event_pending_flag, flagBits}, 9'h000);
    $display("address sent and byte sent test done");
    ev(fb(FLAG_ACK_FAIL));
    `CHK(flagBits, fb(FLAG_ACK_FAIL) | fb(FLAG_BYTE_DONE));
    cpu(RD_ONE, 8'h00);
    tick(1);
    `CHK(flagBits, fb(FLAG_BYTE_DONE));
    @(posedge clock) stopRequest <= 1'b1;
    tick(2);
    @(posedge clock) stopRequest <= 1'b0;
    tick(3);
    `CHK({event_pending_flag, flagBits}, 9'h000);
    ev(fb(FLAG_STOP_SEEN));
    `CHK({event_pending_flag, flagBits}, 9'h000);
    ev(fb(FLAG_STOP_SEEN));
    `CHK({event_pending_flag, flagBits}, {1'b1, fb(FLAG_STOP_SEEN)});
    cpu(RD_TWO, 8'h00);
    tick(1);
    `CHK({event_pending_flag, flagBits}, 9'h000);
    ev(fb(FLAG_ACK_FAIL));
    cpu(RD_ONE, 8'h00);
    cpu(RD_DATA, 8'h00);
    `CHK(flagBits, fb(FLAG_BYTE_DONE));
    cpu(WR_DATA, RELEASE_BYTE);
    tick(1);
    `CHK({event_pending_flag, flagBits, txByte}, 17'h000ff);
    $display("acknowledge failure test done");
    @(posedge clock) cpuHalt <= 1'b1;
    tick(8);
    `CHK(linkAckEnable, 1'b0);
    ev(fb(FLAG_BUS_ERROR));
    `CHK({event_pending_flag, flagBits}, 9'h000);
    cpu(WR_DATA, 8'h77);
    `CHK({txByte, loadCount}, 16'hff04);
    @(posedge clock) cpuHalt <= 1'b0;
    tick(8);
    $display("halt test done");
    for (int i = 0; i < RX_FIFO_DEPTH; i++)
    begin
      i_tws_link_model.send(8'h40 + 8'(i), 40, taken);
      `CHK(taken, 1'b1);
    end
    i_tws_link_model.send(8'hee, 40, taken);
    `CHK(taken, 1'b1);
    i_tws_link_model.send(8'hef, 40, taken);
    `CHK(taken, 1'b0);
    tick(6);
    `CHK({rxValid, flagBits}, {1'b1, fb(FLAG_BYTE_DONE)});
    `CHK(rxByte, 8'h40);
    cpu(RD_ONE, 8'h00);
    cpu(RD_DATA, 8'h00);
    `CHK(flagBits, fb(FLAG_BYTE_DONE));
    `CHK(rxByte, 8'h41);
    cpu(RD_DATA, 8'h00);
    `CHK(flagBits, fb(FLAG_BYTE_DONE));
    for (int i = 2; i < RX_FIFO_DEPTH; i++)
    begin
      `CHK(rxByte, 8'h40 + 8'(i));
      cpu(RD_DATA, 8'h00);
    end
    `CHK(rxByte, 8'hee);
    cpu(RD_ONE, 8'h00);
    cpu(RD_DATA, 8'h00);
    tick(2);
    `CHK({rxValid, event_pending_flag, flagBits}, 10'h000);
    $display("receive buffer test done");
    closeOut();
  end
endmodule
